// ---- rtl/lfw_pkg.sv ----
// package: constants and carrier types for the firmware memory write target
package lfw_pkg;

  // ****************************************************************
  // link field codes
  // ****************************************************************
  localparam logic [3:0] START_WRITE = 4'hE;
  localparam logic [3:0] START_READ  = 4'hD;
  localparam logic [3:0] SIZE_ONE    = 4'h0;
  localparam logic [3:0] READY_SYNC  = 4'h0;
  localparam logic [3:0] NIB_ONES    = 4'hF;

  // ****************************************************************
  // field counts and address layout
  // ****************************************************************
  localparam logic [2:0] ADDR_LAST   = 3'h6;
  localparam logic [2:0] CNT_ZERO    = 3'h0;
  localparam logic [2:0] CNT_ONE     = 3'h1;
  localparam int         ADDR_W      = 28;
  localparam int         SPACE_BIT   = 22;
  localparam int         LOW_ADDR_W  = 19;
  localparam int         SYNC_STAGES = 3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_START = 10'h002,
    ST_ADDR  = 10'h004,
    ST_SIZE  = 10'h008,
    ST_DATA  = 10'h010,
    ST_TARH  = 10'h020,
    ST_SYNC  = 10'h040,
    ST_TARD  = 10'h080,
    ST_REL   = 10'h100,
    ST_IGN   = 10'h200
  } lfw_state_e;

  typedef struct packed {
    logic       frame_n;
    logic [3:0] lad;
  } lfw_link_s;

  typedef struct packed {
    logic                  space;
    logic [LOW_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } lfw_wr_s;

endpackage

// ---- rtl/lfw_target.sv ----
// firmware memory write target: link sampler, cycle decoder and bus turnaround
`timescale 1ns/1ps
module lfw_target (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  input  wire logic        LCLK_I,
  input  wire logic        LFRAME_N_I,
  input  wire logic [3:0]  LAD_I,
  input  wire logic [3:0]  STRAP_ID_I,
  input  wire logic        BUSY_I,
  output logic      [3:0]  LAD_O,
  output logic             LAD_OE_N_O,
  output logic             WR_VALID_O,
  output logic             WR_SPACE_O,
  output logic      [18:0] WR_ADDR_O,
  output logic      [7:0]  WR_DATA_O,
  output logic             RD_START_O
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // link clock, frame and data share one pipeline so they stay aligned
  logic [lfw_pkg::SYNC_STAGES-1:0] clk_sync_q;
  lfw_pkg::lfw_link_s              link_s1_q;
  lfw_pkg::lfw_link_s              link_s2_q;
  lfw_pkg::lfw_link_s              link_s3_q;
  logic [3:0]                      id_s1_q;
  logic [3:0]                      id_s2_q;
  logic [3:0]                      id_s3_q;
  logic [3:0]                      strap_id_q;
  logic                            lclk_lvl_q;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      clk_sync_q <= '0;
      link_s1_q  <= '1;
      link_s2_q  <= '1;
      link_s3_q  <= '1;
      id_s1_q    <= 4'h0;
      id_s2_q    <= 4'h0;
      id_s3_q    <= 4'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], LCLK_I};
      link_s1_q  <= '{frame_n: LFRAME_N_I, lad: LAD_I};
      link_s2_q  <= link_s1_q;
      link_s3_q  <= link_s2_q;
      id_s1_q    <= STRAP_ID_I;
      id_s2_q    <= id_s1_q;
      id_s3_q    <= id_s2_q;
    end
  end

  wire clk_agree = (clk_sync_q[1] == clk_sync_q[2]);
  wire id_agree  = (id_s2_q == id_s3_q);
  // a link edge counts only once stages two and three agree on high
  wire link_edge = clk_agree && clk_sync_q[2] && !lclk_lvl_q;
  wire frame_low = !link_s3_q.frame_n;
  wire [3:0] nib = link_s3_q.lad;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lclk_lvl_q <= 1'b0;
      strap_id_q <= 4'h0;
    end else begin
      lclk_lvl_q <= clk_agree ? clk_sync_q[2] : lclk_lvl_q;
      strap_id_q <= id_agree ? id_s3_q : strap_id_q;
    end
  end

  // ****************************************************************
  // cycle decoder
  // ****************************************************************
  lfw_pkg::lfw_state_e state_q;
  lfw_pkg::lfw_state_e state_d;
  logic [3:0]          code_q;
  logic [3:0]          code_d;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;
  logic [27:0]         addr_q;
  logic [27:0]         addr_d;
  logic [7:0]          data_q;
  logic [7:0]          data_d;

  wire is_write   = (code_q == lfw_pkg::START_WRITE);
  wire is_read    = (code_q == lfw_pkg::START_READ);
  wire id_match   = (nib == strap_id_q);
  wire size_ok    = (nib == lfw_pkg::SIZE_ONE);
  wire addr_done  = (cnt_q == lfw_pkg::ADDR_LAST);
  wire data_done  = (cnt_q == lfw_pkg::CNT_ONE);
  wire tar_last   = (cnt_q == lfw_pkg::CNT_ONE);
  wire in_cycle   = (state_q != lfw_pkg::ST_IDLE) && (state_q != lfw_pkg::ST_START);
  wire abort_ev   = link_edge && frame_low && in_cycle;
  wire read_ev    = link_edge && !frame_low && (state_q == lfw_pkg::ST_START) && is_read;
  // the write is issued as the device takes the bus; busy swallows it silently
  wire wr_fire    = link_edge && !frame_low && (state_q == lfw_pkg::ST_TARH) && tar_last
                    && !BUSY_I;
  wire drive_next = (state_d == lfw_pkg::ST_SYNC) || (state_d == lfw_pkg::ST_TARD);

  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    data_d  = data_q;
    if (link_edge) begin
      if (frame_low) begin
        // any low frame restarts capture; an abort nibble simply never matches
        state_d = lfw_pkg::ST_START;
        code_d  = nib;
      end else begin
        case (state_q)
          lfw_pkg::ST_START: begin
            cnt_d = lfw_pkg::CNT_ZERO;
            if (is_write && id_match) begin
              state_d = lfw_pkg::ST_ADDR;
            end else if (is_write) begin
              state_d = lfw_pkg::ST_IGN;
            end else begin
              state_d = lfw_pkg::ST_IDLE;
            end
          end
          lfw_pkg::ST_ADDR: begin
            addr_d = {addr_q[23:0], nib};
            cnt_d  = cnt_q + 3'h1;
            if (addr_done) begin
              state_d = lfw_pkg::ST_SIZE;
            end
          end
          lfw_pkg::ST_SIZE: begin
            cnt_d   = lfw_pkg::CNT_ZERO;
            state_d = size_ok ? lfw_pkg::ST_DATA : lfw_pkg::ST_IGN;
          end
          lfw_pkg::ST_DATA: begin
            data_d = data_done ? {nib, data_q[3:0]} : {data_q[7:4], nib};
            cnt_d  = cnt_q + 3'h1;
            if (data_done) begin
              cnt_d   = lfw_pkg::CNT_ZERO;
              state_d = lfw_pkg::ST_TARH;
            end
          end
          lfw_pkg::ST_TARH: begin
            // clock thirteen still belongs to the host; the bus is taken one edge later
            cnt_d   = lfw_pkg::CNT_ONE;
            state_d = tar_last ? lfw_pkg::ST_SYNC : lfw_pkg::ST_TARH;
          end
          lfw_pkg::ST_SYNC: state_d = lfw_pkg::ST_TARD;
          lfw_pkg::ST_TARD: state_d = lfw_pkg::ST_REL;
          lfw_pkg::ST_REL:  state_d = lfw_pkg::ST_IDLE;
          lfw_pkg::ST_IGN:  state_d = lfw_pkg::ST_IGN;
          lfw_pkg::ST_IDLE: state_d = lfw_pkg::ST_IDLE;
          default:          state_d = lfw_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= lfw_pkg::ST_IDLE;
      code_q  <= lfw_pkg::NIB_ONES;
      cnt_q   <= lfw_pkg::CNT_ZERO;
      addr_q  <= 28'h0;
      data_q  <= 8'h0;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
    end
  end

  // ****************************************************************
  // pin drivers and user side
  // ****************************************************************
  // outputs follow the next state so the bus turns within one system clock
  lfw_pkg::lfw_wr_s wr_q;
  lfw_pkg::lfw_wr_s wr_d;
  logic             wr_valid_q;
  logic             rd_start_q;
  logic [3:0]       lad_q;
  logic             lad_oe_n_q;

  assign wr_d = '{space: addr_q[lfw_pkg::SPACE_BIT],
                  addr:  addr_q[lfw_pkg::LOW_ADDR_W-1:0],
                  data:  data_q};

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_q       <= '0;
      wr_valid_q <= 1'b0;
      rd_start_q <= 1'b0;
      lad_q      <= lfw_pkg::NIB_ONES;
      lad_oe_n_q <= 1'b1;
    end else begin
      wr_q       <= wr_fire ? wr_d : wr_q;
      wr_valid_q <= wr_fire;
      rd_start_q <= read_ev;
      lad_q      <= (state_d == lfw_pkg::ST_SYNC) ? lfw_pkg::READY_SYNC
                                                  : lfw_pkg::NIB_ONES;
      lad_oe_n_q <= !drive_next;
    end
  end

  assign LAD_O      = lad_q;
  assign LAD_OE_N_O = lad_oe_n_q;
  assign WR_VALID_O = wr_valid_q;
  assign WR_SPACE_O = wr_q.space;
  assign WR_ADDR_O  = wr_q.addr;
  assign WR_DATA_O  = wr_q.data;
  assign RD_START_O = rd_start_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  start_capture_a: assert property (
    link_edge && frame_low |=> state_q == lfw_pkg::ST_START && code_q == $past(nib))
    else $error("start nibble not captured");
  id_miss_a: assert property (
    link_edge && !frame_low && state_q == lfw_pkg::ST_START && is_write && !id_match
    |=> state_q == lfw_pkg::ST_IGN)
    else $error("select mismatch not ignored");
  size_bad_a: assert property (
    link_edge && !frame_low && state_q == lfw_pkg::ST_SIZE && !size_ok
    |=> state_q == lfw_pkg::ST_IGN)
    else $error("bad size not ignored");
  sync_drive_a: assert property (
    state_q == lfw_pkg::ST_SYNC |-> !LAD_OE_N_O && LAD_O == lfw_pkg::READY_SYNC)
    else $error("sync nibble not driven");
  tar_drive_a: assert property (
    state_q == lfw_pkg::ST_TARD |-> !LAD_OE_N_O && LAD_O == lfw_pkg::NIB_ONES)
    else $error("turnaround ones not driven");
  bus_release_a: assert property (
    state_q inside {lfw_pkg::ST_IGN, lfw_pkg::ST_REL, lfw_pkg::ST_IDLE, lfw_pkg::ST_TARH}
    |-> LAD_OE_N_O)
    else $error("bus driven outside owned clocks");
  abort_stop_a: assert property (
    abort_ev |=> state_q == lfw_pkg::ST_START ##1 LAD_OE_N_O)
    else $error("abort did not end cycle");
  busy_block_a: assert property (
    link_edge && state_q == lfw_pkg::ST_TARH && tar_last && !frame_low && BUSY_I
    |=> !WR_VALID_O && state_q == lfw_pkg::ST_SYNC)
    else $error("write issued while busy");
  space_sel_a: assert property (
    wr_fire |=> WR_VALID_O && WR_SPACE_O == $past(addr_q[lfw_pkg::SPACE_BIT]))
    else $error("space bit not routed");
  host_tar_a: assert property (
    link_edge && !frame_low && state_q == lfw_pkg::ST_TARH && !tar_last
    |=> state_q == lfw_pkg::ST_TARH && LAD_OE_N_O)
    else $error("bus taken during host turnaround");
  bus_take_a: assert property (
    link_edge && !frame_low && state_q == lfw_pkg::ST_TARH && tar_last
    |=> state_q == lfw_pkg::ST_SYNC && !LAD_OE_N_O)
    else $error("bus not taken after turnaround");
  cycle_end_a: assert property (
    link_edge && !frame_low && state_q == lfw_pkg::ST_REL
    |=> state_q == lfw_pkg::ST_IDLE && LAD_OE_N_O)
    else $error("cycle not completed");
  read_flag_a: assert property (
    read_ev
    |=> RD_START_O && state_q == lfw_pkg::ST_IDLE)
    else $error("read start not flagged");
  addr_shift_a: assert property (
    link_edge && !frame_low && state_q == lfw_pkg::ST_ADDR
    |=> addr_q[3:0] == $past(nib))
    else $error("address nibble not shifted in");

  write_done_c: cover property (state_q == lfw_pkg::ST_REL ##1 state_q == lfw_pkg::ST_IDLE);
  abort_c:      cover property (abort_ev);
  id_miss_c:    cover property (state_q == lfw_pkg::ST_IGN);
  read_seen_c:  cover property (RD_START_O);
  busy_skip_c:  cover property (link_edge && state_q == lfw_pkg::ST_TARH && tar_last && BUSY_I);

endmodule

// ---- tb/lfw_host.sv ----
// host model: drives link clock, frame and data nibbles of firmware memory cycles
`timescale 1ns/1ps
module lfw_host (
  output logic            lclk_o,
  output logic            frame_n_o,
  output logic      [3:0] lad_o,
  output logic            lad_en_o,
  input  wire logic       dev_oe_n_i,
  input  wire logic [3:0] lad_i
);
  logic [4:0] seen [1:17];

  initial begin
    lclk_o = 1'b0;
    frame_n_o = 1'b1;
    lad_o = 4'hF;
    lad_en_o = 1'b0;
  end

  // link clock only runs inside a cycle; fields change mid-period, far from the rising edge
  task automatic tick(input logic fr_n, input logic en, input logic [3:0] nib, input int n);
    frame_n_o = fr_n;
    lad_en_o = en;
    lad_o = nib;
    #62.5 lclk_o = 1'b1;
    if (n > 0) seen[n] = {dev_oe_n_i, lad_i};
    #62.5 lclk_o = 1'b0;
  endtask

  task automatic run(input logic [3:0] pre, st, sel, sz, input logic [27:0] a,
                     input logic [7:0] d, input int ab);
    logic [3:0] nib;
    for (int n = 1; n <= 17; n++) seen[n] = 5'h00;
    if (pre != 4'h0) tick(1'b0, 1'b1, pre, 0);
    for (int n = 1; n <= 17; n++) begin
      case (n)
        1:       nib = st;
        2:       nib = sel;
        10:      nib = sz;
        11:      nib = d[3:0];
        12:      nib = d[7:4];
        default: nib = (n <= 9) ? a[39-4*n -: 4] : 4'hF;
      endcase
      if (n == ab) begin
        tick(1'b0, 1'b1, 4'hF, n);
        tick(1'b1, 1'b0, 4'hF, 0);
        return;
      end
      tick((n == 1) ? 1'b0 : 1'b1, (n <= 13), nib, n);
    end
  endtask
endmodule

// ---- tb/tb_lfw_target.sv ----
// testbench: firmware memory write target driven by a host model
`timescale 1ns/1ps
module tb_lfw_target;
  logic        clk, rst_n, busy, oe_n, wr_v, wr_sp, rd_st, lclk, fr_n, h_en;
  logic [3:0]  strap, lad_o, lad_w, h_lad;
  logic [18:0] wr_a;
  logic [7:0]  wr_d;
  int          mismatches = 0;
  int          checked = 0;
  int          wr_cnt = 0;
  int          rd_cnt = 0;
  int          drv_cnt = 0;
  int          cyc = 0;
  int          dw, dr, dd;

  // released bus reads as ones through the pull-ups
  assign lad_w = (oe_n === 1'b0) ? lad_o : (h_en ? h_lad : 4'hF);

  lfw_target dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .LCLK_I(lclk), .LFRAME_N_I(fr_n),
    .LAD_I(lad_w), .STRAP_ID_I(strap), .BUSY_I(busy), .LAD_O(lad_o), .LAD_OE_N_O(oe_n),
    .WR_VALID_O(wr_v), .WR_SPACE_O(wr_sp), .WR_ADDR_O(wr_a), .WR_DATA_O(wr_d),
    .RD_START_O(rd_st));
  lfw_host host (.lclk_o(lclk), .frame_n_o(fr_n), .lad_o(h_lad), .lad_en_o(h_en),
    .dev_oe_n_i(oe_n), .lad_i(lad_w));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulses last one cycle, so they are counted rather than sampled later
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_v === 1'b1) wr_cnt <= wr_cnt + 1;
    if (rd_st === 1'b1) rd_cnt <= rd_cnt + 1;
    if (oe_n === 1'b0) drv_cnt <= drv_cnt + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic xfer(input logic [3:0] pre, st, sel, sz, input logic [27:0] a,
                      input logic [7:0] d, input int ab);
    int w0, r0, v0;
    w0 = wr_cnt;
    r0 = rd_cnt;
    v0 = drv_cnt;
    host.run(pre, st, sel, sz, a, d, ab);
    repeat (12) @(posedge clk);
    dw = wr_cnt - w0;
    dr = rd_cnt - r0;
    dd = drv_cnt - v0;
  endtask

  // ******************************
  // scenarios
  // ******************************
  task automatic t_write(input logic [27:0] a, input logic [7:0] d, input logic [19:0] e);
    xfer(4'hC, 4'hE, 4'h5, 4'h0, a, d, 0);
    chk(dw, 1);
    chk({wr_sp, wr_a}, e);
    chk(wr_d, d);
    chk({host.seen[15], host.seen[16], host.seen[17]}, {5'h00, 5'h0F, 5'h1F});
  endtask

  task automatic t_silent(input logic [3:0] st, sel, sz, input int ab);
    xfer(4'h0, st, sel, sz, 28'h5A5A5A5, 8'h66, ab);
    chk(dw, 0);
    chk(dd, 0);
  endtask

  task automatic t_busy();
    #1 busy = 1'b1;
    xfer(4'h0, 4'hE, 4'h5, 4'h0, 28'h0400001, 8'h11, 0);
    #1 busy = 1'b0;
    chk(dw, 0);
    chk({host.seen[15], host.seen[16]}, {5'h00, 5'h0F});
  endtask

  task automatic t_read();
    xfer(4'h0, 4'hD, 4'h5, 4'h0, 28'h0400010, 8'h00, 0);
    chk(dr, 1);
    chk(dw, 0);
    chk(dd, 0);
  endtask

  initial begin
    rst_n = 1'b0;
    busy = 1'b0;
    strap = 4'h5;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({oe_n, lad_o, wr_v, rd_st}, 7'h7C);
    repeat (8) @(posedge clk);
    t_write(28'hB5ABCDE, 8'hA5, {1'b1, 19'h2BCDE});
    t_write(28'h0A81234, 8'h3C, {1'b0, 19'h01234});
    t_silent(4'hE, 4'h6, 4'h0, 0);
    t_silent(4'hE, 4'h5, 4'h1, 0);
    t_silent(4'hE, 4'h5, 4'hF, 0);
    t_silent(4'hC, 4'h5, 4'h0, 0);
    t_silent(4'hE, 4'h5, 4'h0, 6);
    t_silent(4'hE, 4'h5, 4'h0, 12);
    t_write(28'hB5ABCDE, 8'h5A, {1'b1, 19'h2BCDE});
    t_busy();
    t_read();
    t_write(28'h0A81234, 8'hC3, {1'b0, 19'h01234});
    print_verdict();
  end
endmodule
